// >>> hw/empca_pkg.sv
// Purpose: shared constants, types and helpers for the narrow port clock and arbitration block
// Assumes: one clock (aclk, 125 MHz) stands in for the cpu clock; registers reached over AXI4-Lite
// Notes: strobes are active low; strap decode and register map are kept here
// Overview of operation
// - latch port input clock source from two strap pins at reset: ext, cpu/4, cpu/6.
// - without a strap choice the external clock pin is the port input clock.
// - divided output clock is port input clock over a programmable 1, 2 or 4.
// - full output clock runs at the port input clock frequency, undivided.
// - synchronous interface: shared strobe is an address strobe when read_enable_select is 0.
// - synchronous interface: shared strobe is a read enable when read_enable_select is 1.
// - first strobe pin: async read enable, sdram column strobe, sync address strobe/read enable.
// - second strobe pin: async output enable, sdram row strobe, sync output enable.
// - third strobe pin is the write enable for every memory type.
// - a dedicated output enable serves chip space three for a glueless fifo.
// - the device answers a hold request with the hold acknowledge output.
// - the device drives a bus request output while it needs the port bus.
package empca_pkg;

   // register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_ACCESS = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;

   // axi answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // cpu clock halves: a level toggles every N cycles, period 2N
   localparam logic [1:0] HALF_DIV4 = 2'h2;
   localparam logic [1:0] HALF_DIV6 = 2'h3;

   // cycles after reset release before the strap pins are trusted
   localparam logic [2:0] STRAP_SETTLE_CYC = 3'h4;

   // chip space served by the fifo output enable
   localparam logic [1:0] FIFO_SPACE = 2'h3;

   typedef enum logic [1:0] {
      SRC_EXT = 2'b00,
      SRC_DIV4 = 2'b01,
      SRC_DIV6 = 2'b10
   } empca_src_e;

   typedef enum logic [1:0] {
      DIV_BY1 = 2'b00,
      DIV_BY2 = 2'b01,
      DIV_BY4 = 2'b10
   } empca_div_e;

   typedef enum logic [1:0] {
      MEM_ASYNC = 2'b00,
      MEM_SDRAM = 2'b01,
      MEM_SYNC = 2'b10
   } empca_mem_e;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_PH1 = 3'b001,
      ST_PH2 = 3'b010,
      ST_REL = 3'b011,
      ST_HOLD = 3'b100
   } empca_state_e;

   // control register fields, high bits first down to bit 0
   typedef struct packed {
      logic [1:0] space;      // [6:5] chip space of the access
      logic [1:0] div;        // [4:3] divided clock factor code
      logic re_sel;           // [2] read_enable_select
      logic [1:0] mem;        // [1:0] memory type
   } empca_ctrl_s;

   localparam empca_ctrl_s CTRL_RST = 7'h00;

   // the four strobe pins, all active low
   typedef struct packed {
      logic rd_cas_n;
      logic oe_ras_n;
      logic we_n;
      logic fifo_oe_n;
   } empca_strobe_s;

   localparam empca_strobe_s STROBE_IDLE = 4'hf;

   // strap pattern to clock source; unlisted patterns keep the pin clock
   function automatic empca_src_e strap_decode(input logic [1:0] strap);
      empca_src_e r;
      r = SRC_EXT;
      if (strap == 2'h1) begin
         r = SRC_DIV4;
      end else if (strap == 2'h2) begin
         r = SRC_DIV6;
      end
      return r;
   endfunction

endpackage

// >>> hw/empca_clkgen.sv
// Purpose: port input clock selection and the two output clocks
// Assumes: ext pin is slower than a quarter of aclk; source is set once after reset
// Notes: port clock is carried as a level plus a one-cycle rise pulse on aclk;
//    a new divide factor is taken only at a port clock rise, so a switch never leaves a runt level
`timescale 1ns/1ps
`default_nettype none
module empca_clkgen
   import empca_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic port_ext_clk_in,
   input wire empca_src_e src,
   input wire logic [1:0] div_code,
   output logic pclk_rise,
   output logic port_clk_out_full,
   output logic port_clk_out_div
);

   typedef struct packed {
      logic [2:0] sync;
      logic ext_f;
      logic [1:0] cnt;
      logic lvl;
      logic rise;
      logic [1:0] dcnt;
      logic [1:0] code;
      logic full;
      logic div;
   } empca_ck_s;

   empca_ck_s s, next_s;

   // source pick, divide and output shaping
   always_comb begin
      next_s = s;
      next_s.sync = {s.sync[1:0], port_ext_clk_in};
      if (s.sync[1] == s.sync[2]) begin
         next_s.ext_f = s.sync[2];
      end
      case (src)
         SRC_DIV4: begin
            if (s.cnt == HALF_DIV4 - 2'h1) begin
               next_s.cnt = 2'h0;
               next_s.lvl = ~s.lvl;
            end else begin
               next_s.cnt = s.cnt + 2'h1;
            end
         end
         SRC_DIV6: begin
            if (s.cnt == HALF_DIV6 - 2'h1) begin
               next_s.cnt = 2'h0;
               next_s.lvl = ~s.lvl;
            end else begin
               next_s.cnt = s.cnt + 2'h1;
            end
         end
         default: begin
            next_s.cnt = 2'h0;
            next_s.lvl = s.ext_f;
         end
      endcase
      next_s.rise = next_s.lvl & ~s.lvl;
      // factor sampled with the rise: every output edge then falls on a rise or a level change
      if (next_s.rise) begin
         next_s.dcnt = s.dcnt + 2'h1;
         next_s.code = div_code;
      end
      next_s.full = next_s.lvl;
      // dcnt bits toggle on port clock rises, giving /2 and /4 cleanly
      case (next_s.code)
         DIV_BY2: next_s.div = next_s.dcnt[0];
         DIV_BY4: next_s.div = next_s.dcnt[1];
         default: next_s.div = next_s.lvl;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign pclk_rise = s.rise;
   assign port_clk_out_full = s.full;
   assign port_clk_out_div = s.div;

endmodule
`default_nettype wire

// >>> hw/empca_top.sv
// Purpose: narrow external memory port clocking, strobe function select and host arbitration
// Assumes: host and strap pins are asynchronous to aclk; one access runs per software go
// Notes: each access has two port clock phases; strobe pins float while the host holds the bus
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module empca_top
   import empca_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // clocks and straps
   input wire logic port_ext_clk_in,
   input wire logic [1:0] clk_select_strap_pins,
   output logic port_clk_out_full,
   output logic port_clk_out_div,
   // arbitration
   input wire logic host_hold_req_in,
   output logic host_hold_ack_out,
   output logic port_bus_req_out,
   // strobe pins and their shared enable
   output empca_strobe_s strobe_pins,
   output logic strobe_oe
);

   typedef struct packed {
      empca_state_e st;
      logic aw_got;
      logic w_got;
      logic [ADDR_W-1:0] waddr;
      logic [7:0] wdat;
      logic wlane;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      empca_ctrl_s ctrl;
      logic pend;
      logic pend_wr;
      logic cur_wr;
      logic [2:0] hold_sync;
      logic hold_f;
      logic [2:0][1:0] strap_sync;
      logic [2:0] settle;
      logic strap_done;
      empca_src_e src;
      empca_strobe_s pins;
      logic oe;
      logic ack;
      logic breq;
   } empca_top_s;

   empca_top_s s, next_s;
   logic pclk_rise;
   logic aw_hs;
   logic w_hs;
   logic ar_hs;
   logic have_aw;
   logic have_w;
   logic [ADDR_W-1:0] wa;
   logic [7:0] wd;
   logic wl;

   // true for the three mapped word addresses
   function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
      return (a == ADDR_W'(ADDR_CTRL)) || (a == ADDR_W'(ADDR_ACCESS))
         || (a == ADDR_W'(ADDR_STATUS));
   endfunction

   // read data for a mapped address, zero elsewhere
   function automatic logic [31:0] read_mux(input logic [ADDR_W-1:0] a, input empca_top_s v);
      logic [31:0] r;
      r = 32'h0;
      if (a == ADDR_W'(ADDR_CTRL)) begin
         r = {25'h0, v.ctrl};
      end else if (a == ADDR_W'(ADDR_ACCESS)) begin
         r = {30'h0, v.pend_wr, v.pend};
      end else if (a == ADDR_W'(ADDR_STATUS)) begin
         r = {26'h0, v.strap_done, v.pend, v.breq, v.ack, v.src};
      end
      return r;
   endfunction

   // strobe levels per state, memory type and direction
   function automatic empca_strobe_s strobe_drive(input empca_state_e st, input empca_ctrl_s c,
                                                  input logic wr);
      empca_strobe_s p;
      logic ph1;
      logic ph2;
      logic act;
      p = STROBE_IDLE;
      ph1 = (st == ST_PH1);
      ph2 = (st == ST_PH2);
      act = ph1 | ph2;
      case (c.mem)
         MEM_SDRAM: begin
            p.oe_ras_n = ~ph1;
            p.rd_cas_n = ~ph2;
            p.we_n = ~(ph2 & wr);
         end
         MEM_SYNC: begin
            if (c.re_sel) begin
               p.rd_cas_n = ~(act & ~wr);
            end else begin
               p.rd_cas_n = ~ph1;
            end
            p.oe_ras_n = ~(ph2 & ~wr);
            p.we_n = ~(ph1 & wr);
         end
         default: begin
            // reserved type code behaves as asynchronous memory
            p.rd_cas_n = ~(act & ~wr);
            p.oe_ras_n = ~(act & ~wr);
            p.we_n = ~(act & wr);
         end
      endcase
      p.fifo_oe_n = ~(act & ~wr & (c.space == FIFO_SPACE));
      return p;
   endfunction

   empca_clkgen u_clkgen (
      .aclk(aclk),
      .aresetn(aresetn),
      .port_ext_clk_in(port_ext_clk_in),
      .src(s.src),
      .div_code(s.ctrl.div),
      .pclk_rise(pclk_rise),
      .port_clk_out_full(port_clk_out_full),
      .port_clk_out_div(port_clk_out_div)
   );

   // handshake readies come straight from state
   assign s_axi_awready = ~s.aw_got & ~s.bvalid;
   assign s_axi_wready = ~s.w_got & ~s.bvalid;
   assign s_axi_arready = ~s.rvalid;
   assign aw_hs = s_axi_awvalid & s_axi_awready;
   assign w_hs = s_axi_wvalid & s_axi_wready;
   assign ar_hs = s_axi_arvalid & s_axi_arready;

   // a write may complete in the same cycle its last half arrives
   assign have_aw = s.aw_got | aw_hs;
   assign have_w = s.w_got | w_hs;
   assign wa = aw_hs ? s_axi_awaddr : s.waddr;
   assign wd = w_hs ? s_axi_wdata[7:0] : s.wdat;
   assign wl = w_hs ? s_axi_wstrb[0] : s.wlane;

   // whole next-state computation
   always_comb begin
      next_s = s;

      // host request and straps: three stages, second and third must agree
      next_s.hold_sync = {s.hold_sync[1:0], host_hold_req_in};
      if (s.hold_sync[1] == s.hold_sync[2]) begin
         next_s.hold_f = s.hold_sync[2];
      end
      next_s.strap_sync = {s.strap_sync[1:0], clk_select_strap_pins};

      // strap caught once after release; src stays on the pin clock until then
      if (!s.strap_done) begin
         if (s.settle != STRAP_SETTLE_CYC) begin
            next_s.settle = s.settle + 3'h1;
         end else if (s.strap_sync[1] == s.strap_sync[2]) begin
            next_s.src = strap_decode(s.strap_sync[2]);
            next_s.strap_done = 1'b1;
         end
      end

      // write channel: address and data taken in either order
      if (aw_hs) begin
         next_s.aw_got = 1'b1;
         next_s.waddr = s_axi_awaddr;
      end
      if (w_hs) begin
         next_s.w_got = 1'b1;
         next_s.wdat = s_axi_wdata[7:0];
         next_s.wlane = s_axi_wstrb[0];
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end
      if (have_aw && have_w && !s.bvalid) begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = addr_ok(wa) ? RESP_OKAY : RESP_SLVERR;
         if (wa == ADDR_W'(ADDR_CTRL) && wl) begin
            next_s.ctrl = wd[6:0];
         end
         // a go while an access is pending is dropped, not queued
         if (wa == ADDR_W'(ADDR_ACCESS) && wl && wd[0] && !s.pend) begin
            next_s.pend = 1'b1;
            next_s.pend_wr = wd[1];
         end
      end

      // read channel: answer registered one edge after the address
      if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end
      if (ar_hs) begin
         next_s.rvalid = 1'b1;
         next_s.rdata = read_mux(s_axi_araddr, s);
         next_s.rresp = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end

      // access and hold sequencing; phases advance on port clock rises
      unique case (s.st)
         ST_IDLE: begin
            if (s.hold_f) begin
               next_s.st = ST_REL;
            end else if (s.pend && pclk_rise) begin
               next_s.st = ST_PH1;
               next_s.cur_wr = s.pend_wr;
            end
         end
         ST_PH1: begin
            // hold is not honoured mid-access; the access runs out first
            if (pclk_rise) begin
               next_s.st = ST_PH2;
            end
         end
         ST_PH2: begin
            if (pclk_rise) begin
               next_s.st = ST_IDLE;
               next_s.pend = 1'b0;
            end
         end
         ST_REL: begin
            next_s.st = ST_HOLD;
         end
         ST_HOLD: begin
            if (!s.hold_f) begin
               next_s.st = ST_IDLE;
            end
         end
         default: begin
            next_s.st = ST_IDLE;
         end
      endcase

      // pin outputs registered from the next state so they move with it
      next_s.pins = strobe_drive(next_s.st, next_s.ctrl, next_s.cur_wr);
      next_s.oe = ~((next_s.st == ST_REL) | (next_s.st == ST_HOLD));
      next_s.ack = (next_s.st == ST_HOLD);
      next_s.breq = next_s.pend;
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '{st: ST_IDLE, aw_got: 1'b0, w_got: 1'b0, waddr: '0, wdat: 8'h00,
                wlane: 1'b0, bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0,
                rdata: 32'h0, rresp: RESP_OKAY, ctrl: CTRL_RST, pend: 1'b0,
                pend_wr: 1'b0, cur_wr: 1'b0, hold_sync: 3'h0, hold_f: 1'b0,
                strap_sync: 6'h00, settle: 3'h0, strap_done: 1'b0, src: SRC_EXT,
                pins: STROBE_IDLE, oe: 1'b1, ack: 1'b0, breq: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   // registered outputs
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign strobe_pins = s.pins;
   assign strobe_oe = s.oe;
   assign host_hold_ack_out = s.ack;
   assign port_bus_req_out = s.breq;

endmodule
`default_nettype wire

// >>> tb/empca_top_properties.sv
// Purpose: concurrent checks on arbitration, strobe pins, port clocks and bus answers
// Assumes: bound to empca_top; strobes active low, idle all ones
// Notes: clock checks bound level length only, the source being strap chosen
`timescale 1ns/1ps
`default_nettype none
module empca_top_properties
   import empca_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic port_clk_out_full,
   input wire logic port_clk_out_div,
   input wire logic host_hold_req_in,
   input wire logic host_hold_ack_out,
   input wire logic port_bus_req_out,
   input wire empca_strobe_s strobe_pins,
   input wire logic strobe_oe
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // grant only once the pins were already let go
   a_ack_after_release: assert property ($rose(host_hold_ack_out) |-> !$past(strobe_oe) && !strobe_oe)
      else $error("hold ack rose with strobes still driven");
   a_ack_keeps_float: assert property (host_hold_ack_out |-> !strobe_oe)
      else $error("strobes driven during hold");
   a_release_when_idle: assert property ($fell(strobe_oe) |-> $past(strobe_pins) == STROBE_IDLE)
      else $error("strobes released in mid access");
   a_ack_drop_cause: assert property ($fell(host_hold_ack_out) |-> !$past(host_hold_req_in) && strobe_oe)
      else $error("hold ack dropped while request held");
   a_strobe_needs_req: assert property (strobe_oe && !port_bus_req_out |-> strobe_pins == STROBE_IDLE)
      else $error("strobe active without bus request");
   a_fifo_oe_read: assert property (!strobe_pins.fifo_oe_n |-> strobe_pins.we_n)
      else $error("fifo output enable during write");
   a_full_clk_level: assert property ($changed(port_clk_out_full) |=> $stable(port_clk_out_full))
      else $error("full clock level too short");
   a_div_clk_level: assert property ($changed(port_clk_out_div) |=> $stable(port_clk_out_div))
      else $error("divided clock level too short");
   a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response withdrawn early");
   a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data withdrawn early");

   c_hold: cover property ($rose(host_hold_ack_out));
   c_fifo: cover property (!strobe_pins.fifo_oe_n);
   c_write: cover property (!strobe_pins.we_n ##1 strobe_pins.we_n);
endmodule
bind empca_top empca_top_properties u_props (.aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .port_clk_out_full, .port_clk_out_div, .host_hold_req_in,
   .host_hold_ack_out, .port_bus_req_out, .strobe_pins, .strobe_oe);
`default_nettype wire

// >>> tb/empca_far_side.sv
// Purpose: external host and port clock oscillator facing the block
// Assumes: oscillator runs free; host moves its request on aclk edges
// Notes: host never withdraws before it has been granted
`timescale 1ns/1ps
`default_nettype none
module empca_far_side
#(
   parameter int EXT_HALF_NS = 40
)
(
   input wire logic aclk,
   input wire logic hold_cmd,
   input wire logic host_hold_ack_out,
   output logic port_ext_clk_in,
   output logic host_hold_req_in
);
   // offset phase so pin edges never meet aclk edges
   initial begin
      port_ext_clk_in = 1'b0;
      host_hold_req_in = 1'b0;
      #3;
      forever #(EXT_HALF_NS) port_ext_clk_in = ~port_ext_clk_in;
   end
   // request on demand, drop only once acknowledged
   always @(posedge aclk) begin
      if (hold_cmd) begin
         host_hold_req_in <= 1'b1;
      end else if (host_hold_ack_out) begin
         host_hold_req_in <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// >>> tb/empca_top_bench.sv
// Purpose: self-checking bench for port clocking, strobe functions and host hold
// Assumes: ext pin period 10 aclk; straps held through reset
// Notes: strobe phases captured as first and last non-idle pattern of an access
`timescale 1ns/1ps
`default_nettype none
module empca_top_bench
   import empca_pkg::*;
;
   typedef struct packed {logic [7:0] ctrl; logic wr; logic [3:0] p1; logic [3:0] p2;} empca_row_s;
   logic aclk = 1'b0, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, hold_cmd;
   logic port_ext_clk_in, port_clk_out_full, port_clk_out_div, host_hold_req_in, host_hold_ack_out;
   logic port_bus_req_out, strobe_oe;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, clk_select_strap_pins, r;
   empca_strobe_s strobe_pins;
   int err_count = 0, n_tests = 0, cyc = 0, i, n, p;
   logic [1:0] straps [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
   logic [1:0] srcs [4] = '{2'h0, 2'h2, 2'h0, 2'h1};
   int pers [4] = '{10, 6, 10, 4};
   // ctrl, write, first and last strobe pattern {rd_cas_n, oe_ras_n, we_n, fifo_oe_n}
   empca_row_s rows [10] = '{'{8'h00, 1'b0, 4'h3, 4'h3}, '{8'h00, 1'b1, 4'hd, 4'hd}, '{8'h01, 1'b0, 4'hb, 4'h7},
      '{8'h01, 1'b1, 4'hb, 4'h5}, '{8'h02, 1'b0, 4'h7, 4'hb}, '{8'h02, 1'b1, 4'h5, 4'h5},
      '{8'h06, 1'b0, 4'h7, 4'h3}, '{8'h06, 1'b1, 4'hd, 4'hd}, '{8'h60, 1'b0, 4'h2, 4'h2},
      '{8'h60, 1'b1, 4'hd, 4'hd}};

   empca_top #(.ADDR_W(8)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_ext_clk_in,
      .clk_select_strap_pins, .port_clk_out_full, .port_clk_out_div, .host_hold_req_in, .host_hold_ack_out,
      .port_bus_req_out, .strobe_pins, .strobe_oe);
   empca_far_side far (.aclk, .hold_cmd, .host_hold_ack_out, .port_ext_clk_in, .host_hold_req_in);

   always #4 aclk = ~aclk;
   // hang guard, well above the few hundred cycles the run needs
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         summarize();
      end
   end

   task automatic summarize();
      if (err_count == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            rs = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            v = s_axi_rdata;
            rs = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask
   task automatic do_reset(input logic [1:0] s);
      @(posedge aclk);
      aresetn <= 1'b0;
      clk_select_strap_pins <= s;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (10) @(posedge aclk);
   endtask
   // rise to rise distance of one port clock output
   task automatic per_of(input logic use_div, output int pd);
      logic pv, v;
      int k, rc;
      pv = 1'b1;
      rc = 0;
      pd = 0;
      for (k = 0; k < 200 && rc < 2; k++) begin
         @(posedge aclk);
         v = use_div ? port_clk_out_div : port_clk_out_full;
         if (v === 1'b1 && pv === 1'b0) rc++;
         if (rc == 1) pd++;
         pv = v;
      end
   endtask
   task automatic run_acc(input empca_row_s row);
      logic [3:0] p1, p2;
      logic seen;
      int k;
      p1 = STROBE_IDLE;
      p2 = STROBE_IDLE;
      seen = 1'b0;
      axi_wr(ADDR_CTRL, {24'h0, row.ctrl}, r);
      axi_wr(ADDR_ACCESS, {30'h0, row.wr, 1'b1}, r);
      for (k = 0; k < 80 && !(seen && port_bus_req_out === 1'b0); k++) begin
         @(posedge aclk);
         if (port_bus_req_out === 1'b1) seen = 1'b1;
         if (strobe_pins !== STROBE_IDLE) begin
            if (p1 === STROBE_IDLE) p1 = strobe_pins;
            p2 = strobe_pins;
         end
      end
      chk({31'h0, seen}, 32'h1);
      chk({24'h0, p1, p2}, {24'h0, row.p1, row.p2});
   endtask

   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, hold_cmd} = 6'h00;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      clk_select_strap_pins = 2'h0;
      // every strap pattern, source code and full clock period
      for (i = 0; i < 4; i++) begin
         do_reset(straps[i]);
         axi_rd(ADDR_STATUS, d, r);
         chk({30'h0, d[1:0]}, {30'h0, srcs[i]});
         per_of(1'b0, p);
         chk(p, pers[i]);
      end
      axi_rd(ADDR_CTRL, d, r);
      chk(d, 32'h0);
      for (i = 0; i < 3; i++) begin
         axi_wr(ADDR_CTRL, i << 3, r);
         per_of(1'b1, p);
         chk(p, 4 << i);
      end
      for (i = 0; i < 10; i++) run_acc(rows[i]);
      // unmapped place
      axi_wr(8'h0c, 32'h1, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      axi_rd(8'h0c, d, r);
      chk({d[29:0], r}, {30'h0, RESP_SLVERR});
      // hold asked while an access is pending, then a go issued under hold
      axi_wr(ADDR_CTRL, 32'h0, r);
      axi_wr(ADDR_ACCESS, 32'h1, r);
      hold_cmd <= 1'b1;
      for (n = 0; n < 100 && host_hold_ack_out !== 1'b1; n++) @(posedge aclk);
      chk({29'h0, host_hold_ack_out, strobe_oe, port_bus_req_out}, 32'h4);
      axi_wr(ADDR_ACCESS, 32'h1, r);
      for (n = 0; n < 100 && port_bus_req_out !== 1'b1; n++) @(posedge aclk);
      chk({29'h0, host_hold_ack_out, strobe_oe, port_bus_req_out}, 32'h5);
      hold_cmd <= 1'b0;
      for (n = 0; n < 100 && host_hold_ack_out !== 1'b0; n++) @(posedge aclk);
      chk({30'h0, host_hold_ack_out, strobe_oe}, 32'h1);
      for (n = 0; n < 100 && port_bus_req_out !== 1'b0; n++) @(posedge aclk);
      chk({31'h0, port_bus_req_out}, 32'h0);
      summarize();
   end
endmodule
`default_nettype wire
